// ### design/fbs_pkg.sv
package fbs_pkg;
  // flash geometry
  localparam int          ADDR_W        = 32;
  localparam int          BLK_W         = 4;
  localparam int          NUM_BLOCKS    = 12;
  localparam logic [31:0] SMALL_BASE    = 32'h0000_0000;
  localparam logic [31:0] SMALL_END     = 32'h0000_ffff;
  localparam logic [31:0] MID_BASE      = 32'h0001_0000;
  localparam logic [31:0] MID_END       = 32'h0001_ffff;
  localparam logic [31:0] LARGE_BASE    = 32'h0002_0000;
  localparam logic [31:0] LARGE_END     = 32'h0007_ffff;
  localparam int          SMALL_SHIFT   = 13;  // 8 KB
  localparam int          LARGE_SHIFT   = 17;  // 128 KB
  localparam logic [3:0]  MID_BLOCK     = 4'h8;
  localparam logic [3:0]  LARGE_FIRST   = 4'h9;
  // program unit
  localparam int          UNIT_BYTES    = 256;
  localparam int          UNIT_IDX_W    = 8;
  localparam logic [7:0]  ERASED_BYTE   = 8'hff;
  // routine download
  localparam int          ROUTINE_WORDS = 16;
  localparam int          ROUTINE_IDX_W = 4;
  localparam logic [31:0] ERASE_RT_TAG  = 32'h0e5a_0000;
  localparam logic [31:0] PROG_RT_TAG   = 32'h0b9a_0000;
  // timing (cycles at 10 MHz per step)
  localparam int          STEP_CYCLES   = 4;
  localparam int          STEP_W        = 3;
  typedef enum logic [1:0] {FBS_OP_NONE, FBS_OP_ERASE, FBS_OP_PROG} fbs_op_t;
endpackage

// ### design/fbs_blkmap.sv
`timescale 1ns/1ps
`default_nettype none
module fbs_blkmap (
  input  wire logic [31:0] addr,
  output logic      [3:0]  blk,
  output logic             valid
);
  import fbs_pkg::*;
  // address to erase block decode
  always_comb begin
    blk   = 4'h0;
    valid = 1'b1;
    if (addr <= SMALL_END) begin
      blk = 4'(addr[SMALL_SHIFT+2:SMALL_SHIFT]);
    end else if (addr <= MID_END) begin
      blk = MID_BLOCK;
    end else if (addr <= LARGE_END) begin
      blk = 4'(LARGE_FIRST - 4'h1
               + 4'(addr[LARGE_SHIFT+1:LARGE_SHIFT]));
    end else begin
      valid = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### design/fbs_seq.sv
`timescale 1ns/1ps
`default_nettype none
module fbs_seq (
  input  wire logic                     CLOCK,
  input  wire logic                     RSTN,
  input  wire logic                     DOWNLOAD_REQ,
  input  wire logic                     DOWNLOAD_ERASE,
  input  wire logic [fbs_pkg::ADDR_W-1:0] DOWNLOAD_TARGET,
  input  wire logic                     CLOCKS_EQUAL,
  input  wire logic                     START,
  input  wire logic [fbs_pkg::ADDR_W-1:0] PARAM_ADDR,
  input  wire logic [7:0]               PARAM_DATA,
  input  wire logic                     PARAM_DATA_VALID,
  output logic                          PARAM_DATA_READY,
  output logic                          RAM_WE,
  output logic [fbs_pkg::ADDR_W-1:0]    RAM_ADDR,
  output logic [31:0]                   RAM_WDATA,
  output logic                          FLASH_ERASE,
  output logic [3:0]                    FLASH_BLOCK,
  output logic                          FLASH_WE,
  output logic [fbs_pkg::ADDR_W-1:0]    FLASH_ADDR,
  output logic [7:0]                    FLASH_WDATA,
  output logic                          DOWNLOAD_DONE,
  output logic                          BUSY,
  output logic                          DONE,
  output logic                          FAIL
);
  import fbs_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_LOAD, S_READY, S_ERASE, S_PROG, S_END
  } fbs_state_t;

  typedef struct packed {
    fbs_state_t               state;
    fbs_op_t                  routine;
    logic [ROUTINE_IDX_W-1:0] widx;
    logic [UNIT_IDX_W:0]      bidx;
    logic [STEP_W-1:0]        step;
    logic [31:0]              base;
    logic [31:0]              target;
    logic                     ram_we;
    logic [31:0]              ram_addr;
    logic [31:0]              ram_wdata;
    logic                     f_erase;
    logic [3:0]               f_blk;
    logic                     f_we;
    logic [31:0]              f_addr;
    logic [7:0]               f_wdata;
    logic                     dl_done;
    logic                     done;
    logic                     fail;
    logic                     d_ready;
    logic                     busy;
  } fbs_regs_t;

  fbs_regs_t  r_reg;
  fbs_regs_t  r_next;
  logic [3:0] map_blk;
  logic       map_ok;

  fbs_blkmap u_map (
    .addr  (PARAM_ADDR),
    .blk   (map_blk),
    .valid (map_ok)
  );

  // next state: download, then erase or program from the loaded routine
  always_comb begin
    r_next         = r_reg;
    r_next.ram_we  = 1'b0;
    r_next.f_erase = 1'b0;
    r_next.f_we    = 1'b0;
    r_next.d_ready = 1'b0;
    case (r_reg.state)
      S_IDLE: begin
        // clocks must run at equal ratio or download is refused
        if (DOWNLOAD_REQ && CLOCKS_EQUAL) begin
          r_next.state   = S_LOAD;
          r_next.base    = DOWNLOAD_TARGET;
          r_next.widx    = '0;
          r_next.routine = DOWNLOAD_ERASE ? FBS_OP_ERASE : FBS_OP_PROG;
          r_next.dl_done = 1'b0;
        end else if (START && r_reg.dl_done) begin
          r_next.state = S_READY;
        end
      end
      S_LOAD: begin
        // one routine word per cycle to target + 4*index
        r_next.ram_we    = 1'b1;
        r_next.ram_addr  = r_reg.base + {26'h0, r_reg.widx, 2'b00};
        r_next.ram_wdata = ((r_reg.routine == FBS_OP_ERASE) ?
                            ERASE_RT_TAG : PROG_RT_TAG) | 32'(r_reg.widx);
        r_next.widx      = r_reg.widx + 1'b1;
        if (r_reg.widx == ROUTINE_IDX_W'(ROUTINE_WORDS - 1)) begin
          r_next.state   = S_IDLE;
          r_next.dl_done = 1'b1;
        end
      end
      S_READY: begin
        // parameters latched once routine is ready
        r_next.done   = 1'b0;
        r_next.fail   = 1'b0;
        r_next.target = PARAM_ADDR;
        r_next.step   = '0;
        r_next.bidx   = '0;
        if (!map_ok) begin
          r_next.fail  = 1'b1;
          r_next.state = S_END;
        end else if (r_reg.routine == FBS_OP_ERASE) begin
          r_next.f_blk = map_blk;
          r_next.state = S_ERASE;
        end else if (PARAM_ADDR[UNIT_IDX_W-1:0] != '0) begin
          r_next.fail  = 1'b1;
          r_next.state = S_END;
        end else begin
          r_next.state = S_PROG;
        end
      end
      S_ERASE: begin
        // whole-block erase strobe after a settle count
        r_next.step = r_reg.step + 1'b1;
        if (r_reg.step == STEP_W'(STEP_CYCLES - 1)) begin
          r_next.f_erase = 1'b1;
          r_next.state   = S_END;
        end
      end
      S_PROG: begin
        // exactly one unit of bytes, each taken on valid while ready is high
        r_next.d_ready = 1'b1;
        if (PARAM_DATA_VALID && r_reg.d_ready) begin
          r_next.f_we    = 1'b1;
          r_next.f_addr  = r_reg.target + 32'(r_reg.bidx);
          r_next.f_wdata = PARAM_DATA;
          r_next.bidx    = r_reg.bidx + 1'b1;
          if (r_reg.bidx == (UNIT_IDX_W+1)'(UNIT_BYTES - 1)) begin
            r_next.d_ready = 1'b0;
            r_next.state   = S_END;
          end
        end
      end
      S_END: begin
        r_next.done  = 1'b1;
        r_next.state = S_IDLE;
      end
      default: r_next.state = S_IDLE;
    endcase
    // busy kept as a register bit so the port has no decode glitches
    r_next.busy = (r_next.state != S_IDLE);
  end

  // state register
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      r_reg       <= '0;
      r_reg.state <= S_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign RAM_WE           = r_reg.ram_we;
  assign RAM_ADDR         = r_reg.ram_addr;
  assign RAM_WDATA        = r_reg.ram_wdata;
  assign FLASH_ERASE      = r_reg.f_erase;
  assign FLASH_BLOCK      = r_reg.f_blk;
  assign FLASH_WE         = r_reg.f_we;
  assign FLASH_ADDR       = r_reg.f_addr;
  assign FLASH_WDATA      = r_reg.f_wdata;
  assign DOWNLOAD_DONE    = r_reg.dl_done;
  assign BUSY             = r_reg.busy;
  assign DONE             = r_reg.done;
  assign FAIL             = r_reg.fail;
  assign PARAM_DATA_READY = r_reg.d_ready;

  // a unit always ends after 256 byte writes
  chk_unit_len: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (FLASH_WE && r_reg.state == S_END) |-> r_reg.bidx == 9'h100)
    else $error("program unit length wrong");
  // erase strobe names a real block, then a pass result follows
  chk_erase_blk: assert property (@(posedge CLOCK) disable iff (!RSTN)
    FLASH_ERASE |-> (FLASH_BLOCK <= 4'hb) ##1 (DONE && !FAIL))
    else $error("erase without result");
  // first routine word lands at the target address
  chk_load_addr: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (r_reg.state == S_LOAD && r_reg.widx == 4'h0)
      |=> RAM_WE && RAM_ADDR == r_reg.base)
    else $error("routine not at target address");
  // start ignored before a download
  chk_start_gate: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (r_reg.state == S_IDLE && START && !DOWNLOAD_REQ && !r_reg.dl_done)
      |=> r_reg.state == S_IDLE)
    else $error("start without routine");
  // download refused unless clocks equal
  chk_clk_ratio: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (r_reg.state == S_IDLE && DOWNLOAD_REQ && !CLOCKS_EQUAL)
      |=> r_reg.state != S_LOAD)
    else $error("download with unequal clocks");
  // small, mid and large block decode
  chk_small_map: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (PARAM_ADDR <= SMALL_END) |-> map_blk == 4'(PARAM_ADDR[15:13]))
    else $error("small block map wrong");
  chk_mid_map: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (PARAM_ADDR[31:16] == 16'h0001) |-> map_blk == 4'h8)
    else $error("mid block map wrong");
  chk_large_map: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (PARAM_ADDR >= LARGE_BASE && PARAM_ADDR <= LARGE_END)
      |-> map_blk == 4'(4'h8 + 4'(PARAM_ADDR[18:17])))
    else $error("large block map wrong");
  // misaligned program start fails
  chk_align_fail: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (r_reg.state == S_READY && r_reg.routine == FBS_OP_PROG && map_ok
      && PARAM_ADDR[7:0] != 8'h00) |=> FAIL ##1 DONE)
    else $error("misaligned start accepted");
endmodule
`default_nettype wire

// ### tb/fbs_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// software side feeding one program unit into the sequencer
module fbs_cpu_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       slow,
  input  wire logic [8:0] len,
  input  wire logic       ready,
  output logic      [7:0] data,
  output logic            valid
);
  int   idx = 0;
  logic hs = 1'b0;
  logic gap = 1'b0;
  logic run = 1'b0;
  initial data = 8'h00;
  initial valid = 1'b0;
  // handshake and go seen at the sampling edge; go is also driven on the
  // falling edge, so reading it there would race the bench
  always @(posedge clk) begin
    hs = valid && ready;
    run = go;
  end
  // drive at falling edge; a slow cpu idles one cycle after each byte
  always @(negedge clk) begin
    if (!run) begin
      idx = 0;
    end else if (hs) begin
      idx = idx + 1;
    end
    gap = hs && slow;
    valid = run && (idx < 256) && !gap;
    if (valid) begin
      // short unit topped up with erased bytes
      data = (idx < len) ? (idx[7:0] ^ 8'h5a) : 8'hff;
    end else begin
      data = ~data; // inverted while idle: no stale value
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fbs_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, dl_req = 1'b0, dl_erase = 1'b0;
  logic eq = 1'b1, start = 1'b0, go = 1'b0, slow = 1'b0;
  logic [31:0] dl_tgt = 32'h0, p_addr = 32'h0, exp_ram, exp_fl;
  logic [31:0] rt_tag;
  logic [8:0] len = 9'h0;
  logic [7:0] p_data;
  logic p_valid, p_ready, ram_we, fl_erase, fl_we, dl_done, busy, done, fail;
  logic [31:0] ram_addr, ram_wdata, fl_addr;
  logic [7:0] fl_wdata;
  logic [3:0] fl_blk;
  int errors = 0, total_checks = 0, ram_cnt = 0, fl_cnt = 0, er_cnt = 0;
  fbs_seq fbs_seq_inst (.CLOCK(clock), .RSTN(rstn), .DOWNLOAD_REQ(dl_req),
    .DOWNLOAD_ERASE(dl_erase), .DOWNLOAD_TARGET(dl_tgt), .CLOCKS_EQUAL(eq),
    .START(start), .PARAM_ADDR(p_addr), .PARAM_DATA(p_data),
    .PARAM_DATA_VALID(p_valid), .PARAM_DATA_READY(p_ready),
    .RAM_WE(ram_we), .RAM_ADDR(ram_addr), .RAM_WDATA(ram_wdata),
    .FLASH_ERASE(fl_erase), .FLASH_BLOCK(fl_blk), .FLASH_WE(fl_we),
    .FLASH_ADDR(fl_addr), .FLASH_WDATA(fl_wdata),
    .DOWNLOAD_DONE(dl_done), .BUSY(busy), .DONE(done), .FAIL(fail));
  fbs_cpu_model fbs_cpu_model_inst (.clk(clock), .go(go), .slow(slow),
    .len(len), .ready(p_ready), .data(p_data), .valid(p_valid));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // watch the write strobes mid-cycle, where they have settled
  always @(negedge clock) begin
    if (ram_we === 1'b1) begin
      chk("ram addr", exp_ram, ram_addr);
      chk("ram word", rt_tag | ram_cnt, ram_wdata);
      exp_ram = exp_ram + 32'h4;
      ram_cnt++;
    end
    if (fl_we === 1'b1) begin
      chk("flash addr", exp_fl + fl_cnt, fl_addr);
      chk("flash byte", (fl_cnt < len) ? ((fl_cnt & 8'hff) ^ 8'h5a)
        : 8'hff, {24'h0, fl_wdata});
      fl_cnt++;
    end
    if (fl_erase === 1'b1) er_cnt++;
  end
  initial forever #50 clock = ~clock;
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic dl(input logic er, input logic [31:0] t, input logic q);
    @(negedge clock);
    dl_erase = er;
    dl_tgt = t;
    eq = q;
    exp_ram = t;
    ram_cnt = 0;
    rt_tag = er ? ERASE_RT_TAG : PROG_RT_TAG;
    dl_req = 1'b1;
    @(negedge clock);
    dl_req = 1'b0;
    repeat (20) @(negedge clock);
    chk("words", q ? 16 : 0, ram_cnt);
  endtask
  task automatic op(input logic [31:0] a, input int n, input logic s);
    @(negedge clock);
    p_addr = a;
    exp_fl = a;
    fl_cnt = 0;
    er_cnt = 0;
    len = n[8:0];
    slow = s;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    go = 1'b1;
    // the previous result clears one edge later; wait it out
    @(negedge clock);
    chk("busy", 1, busy);
    for (int i = 0; i < 2000 && done !== 1'b1; i++) @(negedge clock);
    chk("done", 1, done);
    chk("idle", 0, busy);
    go = 1'b0;
  endtask
  task automatic t_early;
    // start with no routine loaded must be ignored
    @(negedge clock);
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    repeat (2) @(negedge clock);
    chk("early busy", 0, busy);
    chk("early done", 0, done);
    chk("early dl", 0, dl_done);
  endtask
  task automatic t_erase(input logic [31:0] a, input logic [3:0] b,
                         input logic f);
    op(a, 0, 1'b0);
    chk("fail", f, fail);
    chk("erases", f ? 0 : 1, er_cnt);
    if (!f) chk("block", b, fl_blk);
  endtask
  task automatic t_prog(input logic [31:0] a, input int n, input logic s,
                        input logic f);
    op(a, n, s);
    chk("fail", f, fail);
    chk("bytes", f ? 0 : 256, fl_cnt);
    chk("ready", 0, p_ready);
  endtask
  initial begin
    #(100 * 30000);
    errors++;
    conclude();
  end
  initial begin
    repeat (6) @(negedge clock);
    rstn = 1'b1;
    t_early();
    dl(1'b1, 32'hfff8_1000, 1'b0);
    dl(1'b1, 32'hfff8_1000, 1'b1);
    chk("dl done", 1, dl_done);
    t_erase(32'h0000_1fff, 4'h0, 1'b0);
    t_erase(32'h0000_e000, 4'h7, 1'b0);
    t_erase(32'h0001_0000, 4'h8, 1'b0);
    t_erase(32'h0001_ffff, 4'h8, 1'b0);
    t_erase(32'h0002_0000, 4'h9, 1'b0);
    t_erase(32'h0005_ffff, 4'ha, 1'b0);
    t_erase(32'h0007_ffff, 4'hb, 1'b0);
    t_erase(32'h0008_0000, 4'h0, 1'b1);
    t_erase(32'h0000_3fff, 4'h1, 1'b0);
    dl(1'b0, 32'hfff8_2000, 1'b1);
    t_prog(32'h0000_2100, 200, 1'b1, 1'b0);
    t_prog(32'h0000_2200, 256, 1'b0, 1'b0);
    t_prog(32'h0000_2180, 256, 1'b0, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
